// *** hdl/mps_pkg.sv ***
// Overview of operation
// R1: supply ready and enable above high level starts the power-up sequence
// R2: enable below low level shuts down and clears every latched fault
// R3: first boot senses configuration pins inside the init window
// R4: fixed delay before soft-start; outputs float there on first boot
// R5: soft-start slew comes from config pin one, a register bit overrides
// R6: power good released once the output reaches reference after the ramp
// R7: enable high to power good finishes within the start-up bound
// R8: register reads and writes are ignored until start-up completes
// R9: mid-level drive off at first boot, on after sensing if configured
// R10: mid-level drive enabled by register bit or config pin two
// R11: mid-level drive off while enable low, needs recovery time after
// R12: system raises stage driver enable 60 to 100 us after enable
// R13: without mid drive, driver enable leads controller enable by 100 us
// R14: enable re-start skips sensing and reuses the sensed settings
// R15: during a re-start delay the outputs sit at the tri-state level
// R16: registers survive enable toggling, lost only on supply reset
// R17: enable low stops switching after 300 ns, tri-states, pulls power good
// R18: each output gives one low pulse before entering tri-state
// R19: shutdown discharges the output, and the reference in stage mode
// R20: reference adjust output follows the voltage-id input level
// R21: voltage-id active only after power good; before that high impedance
// R22: power good low on faults, enable low and before regulation
// R23: sequencing counters restart on enable low or supply reset
package mps_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;

  localparam int unsigned INIT_WINDOW_NS = 500000;
  localparam int unsigned PRE_SS_NS      = 200000;
  localparam int unsigned MID_RCV_NS     = 50000;
  localparam int unsigned STOP_DLY_NS    = 300;
  localparam int unsigned BOUND_NS       = 1500000;

  // longest times round down, least times round up
  localparam int unsigned INIT_WINDOW_CYC = INIT_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned PRE_SS_CYC =
    (PRE_SS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MID_RCV_CYC =
    (MID_RCV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STOP_DLY_CYC =
    (STOP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BOUND_CYC = BOUND_NS / CLK_PERIOD_NS;

  // soft-start ramp: reference codes and cycles per code for each slew
  localparam int unsigned RAMP_TARGET   = 256;
  localparam int unsigned SLEW_SLOW_CYC = 300;
  localparam int unsigned SLEW_FAST_CYC = 150;

  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_SLEW    = 8'h40;
  localparam logic [7:0] ADDR_MIDDRV  = 8'h43;
  localparam int unsigned SLEW_BIT    = 1;
  localparam int unsigned MIDDRV_BIT  = 3;
  localparam logic [7:0] REG_RST      = 8'h00;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_INIT  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RAMP  = 3'b011,
    ST_GOOD  = 3'b100,
    ST_STOP  = 3'b101,
    ST_LOWP  = 3'b110
  } mps_state_t;

  typedef struct packed {
    logic slew_fast;
    logic mid_en;
  } mps_cfg_t;

  typedef struct packed {
    logic en_hi;
    logic en_lo;
    logic en_sense;
    logic vid;
    logic vout_ok;
    logic uv;
    logic ov;
    logic ot;
    logic cfg_one;
    logic cfg_two;
  } mps_pins_t;

endpackage

// *** hdl/mps_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module mps_sequencer #(
  parameter int unsigned PHASES   = 8,
  parameter int unsigned INIT_CYC = mps_pkg::INIT_WINDOW_CYC,
  parameter int unsigned DLY_CYC  = mps_pkg::PRE_SS_CYC,
  parameter int unsigned MID_CYC  = mps_pkg::MID_RCV_CYC,
  parameter int unsigned BND_CYC  = mps_pkg::BOUND_CYC
) (
  // clock, supply-ready reset, clock enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // analog comparator and strap pins, asynchronous
  input  wire mps_pkg::mps_pins_t pins,
  input  wire logic              integrated_stage_mode,
  // switching demand from the control loop
  input  wire logic [PHASES-1:0] pwm_demand,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // phase outputs: drive level, enable, mid-level drive
  output logic [PHASES-1:0]      pwm_drive,
  output logic [PHASES-1:0]      pwm_oe,
  output logic                   pwm_mid,
  // open-drain power good
  output logic                   power_good_flag_o,
  output logic                   power_good_flag_oe,
  // voltage-id buffer output
  output logic                   reference_adjust_out_o,
  output logic                   reference_adjust_out_oe,
  // stage reference and discharge switches
  output logic                   stage_reference_hold,
  output logic                   stage_reference_discharge,
  output logic                   output_discharge
);

  localparam int unsigned CW = 20;
  localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);
  localparam logic [CW-1:0] DLY_LAST  = CW'(DLY_CYC - 1);
  localparam logic [CW-1:0] MID_DONE  = CW'(MID_CYC);
  localparam logic [CW-1:0] STOP_LAST = CW'(mps_pkg::STOP_DLY_CYC - 1);
  localparam logic [8:0] RAMP_END  = 9'(mps_pkg::RAMP_TARGET);
  localparam logic [8:0] SLOW_LAST = 9'(mps_pkg::SLEW_SLOW_CYC - 1);
  localparam logic [8:0] FAST_LAST = 9'(mps_pkg::SLEW_FAST_CYC - 1);
  localparam int unsigned RAMP_MAX =
    mps_pkg::RAMP_TARGET * mps_pkg::SLEW_SLOW_CYC;

  // the ramp must fit inside the start-up bound, counters inside CW bits
  if (PHASES < 1 || PHASES > 8 || DLY_CYC < 1 || INIT_CYC < 1 ||
      MID_CYC < 1 || BND_CYC >= (1 << CW) || INIT_CYC >= (1 << CW) ||
      MID_CYC >= (1 << CW) || DLY_CYC + RAMP_MAX + 4 > BND_CYC) begin : g_chk
    $error("mps_sequencer: parameters out of range");
  end

  mps_pkg::mps_pins_t   sync_a_r;
  mps_pkg::mps_pins_t   sync_b_r;
  mps_pkg::mps_state_t  state_r;
  mps_pkg::mps_state_t  state_nxt;
  mps_pkg::mps_cfg_t    cfg_r;
  logic [CW-1:0]        cnt_r;
  logic [CW-1:0]        mid_cnt_r;
  logic [CW-1:0]        bnd_cnt_r;
  logic [8:0]           ramp_code_r;
  logic [8:0]           slew_cnt_r;
  logic                 sensed_r;
  logic                 first_boot_r;
  logic                 fault_r;
  logic                 slew_ovr_r;
  logic                 slew_reg_r;
  logic                 mid_ovr_r;
  logic                 mid_reg_r;
  logic                 pg_release_r;
  logic                 en_off;
  logic                 switching;
  logic                 slew_fast;
  logic                 mid_active;
  logic                 bus_open;
  logic                 ramp_done;
  logic                 stopping;
  logic                 mode_a_r;
  logic                 mode_b_r;

  // two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_r <= '0;
      sync_b_r <= '0;
      mode_a_r <= 1'b0;
      mode_b_r <= 1'b0;
    end else if (ce) begin
      sync_a_r <= pins;
      sync_b_r <= sync_a_r;
      mode_a_r <= integrated_stage_mode;
      mode_b_r <= mode_a_r;
    end
  end

  assign en_off    = sync_b_r.en_lo;
  assign switching = (state_r == mps_pkg::ST_RAMP) ||
                     (state_r == mps_pkg::ST_GOOD);
  assign stopping  = (state_r == mps_pkg::ST_STOP) ||
                     (state_r == mps_pkg::ST_LOWP);
  assign ramp_done = (ramp_code_r == RAMP_END);
  assign bus_open  = (state_r == mps_pkg::ST_GOOD); // R8
  assign slew_fast = slew_ovr_r ? slew_reg_r : cfg_r.slew_fast; // R5 R14
  // mid drive needs sensing done, selection, and recovery after enable
  assign mid_active = sensed_r && (mid_ovr_r ? mid_reg_r : cfg_r.mid_en) &&
                      (mid_cnt_r == MID_DONE); // R9 R10 R11

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mps_pkg::ST_OFF: begin
        if (!sensed_r && sync_b_r.en_sense && !en_off) begin
          state_nxt = mps_pkg::ST_INIT; // R3
        end else if (sensed_r && sync_b_r.en_hi) begin
          state_nxt = mps_pkg::ST_DELAY; // R1 R14
        end
      end
      mps_pkg::ST_INIT: begin
        if (cnt_r == INIT_LAST) begin
          state_nxt = mps_pkg::ST_OFF;
        end
      end
      mps_pkg::ST_DELAY: begin
        if (cnt_r == DLY_LAST) begin
          state_nxt = mps_pkg::ST_RAMP; // R4
        end
      end
      mps_pkg::ST_RAMP: begin
        if (ramp_done && sync_b_r.vout_ok) begin
          state_nxt = mps_pkg::ST_GOOD; // R6
        end
      end
      mps_pkg::ST_GOOD: state_nxt = mps_pkg::ST_GOOD;
      mps_pkg::ST_STOP: begin
        if (cnt_r == STOP_LAST) begin
          state_nxt = mps_pkg::ST_LOWP; // R17
        end
      end
      mps_pkg::ST_LOWP: state_nxt = mps_pkg::ST_OFF; // R18
      default: state_nxt = mps_pkg::ST_OFF;
    endcase
    // switching phases finish through the stop delay, stop states run on, others drop at once
    if (en_off && switching) begin
      state_nxt = mps_pkg::ST_STOP; // R2 R17
    end else if (en_off && !stopping) begin
      state_nxt = mps_pkg::ST_OFF; // R2
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mps_pkg::ST_OFF;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // sequencing counter, restarted on every state change and on enable low outside the stop states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (state_nxt != state_r || (en_off && !stopping)) begin
        cnt_r <= '0; // R23
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // mid drive recovery counts only while enable is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mid_cnt_r <= '0;
    end else if (ce) begin
      if (!sync_b_r.en_hi || en_off) begin
        mid_cnt_r <= '0; // R11 R23
      end else if (mid_cnt_r != MID_DONE) begin
        mid_cnt_r <= mid_cnt_r + 1'b1;
      end
    end
  end

  // soft-start reference ramp, one code per slew period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_code_r <= '0;
      slew_cnt_r  <= '0;
    end else if (ce) begin
      if (state_r != mps_pkg::ST_RAMP && state_r != mps_pkg::ST_GOOD) begin
        ramp_code_r <= '0; // R23
        slew_cnt_r  <= '0;
      end else if (!ramp_done) begin
        if (slew_cnt_r == (slew_fast ? FAST_LAST : SLOW_LAST)) begin
          slew_cnt_r  <= '0; // R5
          ramp_code_r <= ramp_code_r + 1'b1;
        end else begin
          slew_cnt_r <= slew_cnt_r + 1'b1;
        end
      end
    end
  end

  // configuration sensing, kept until the supply goes away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sensed_r     <= 1'b0;
      first_boot_r <= 1'b0;
      cfg_r        <= '0;
    end else if (ce) begin
      if (state_r == mps_pkg::ST_INIT && cnt_r == INIT_LAST && !en_off) begin
        sensed_r          <= 1'b1; // R3 R14
        first_boot_r      <= 1'b1;
        cfg_r.slew_fast   <= sync_b_r.cfg_one;
        cfg_r.mid_en      <= sync_b_r.cfg_two;
      end else if (state_r == mps_pkg::ST_GOOD || en_off) begin
        first_boot_r <= 1'b0;
      end
    end
  end

  // latched faults; enable low clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (ce) begin
      if (en_off) begin
        fault_r <= 1'b0; // R2
      end else if (switching &&
                   (sync_b_r.uv || sync_b_r.ov || sync_b_r.ot)) begin
        fault_r <= 1'b1; // R22
      end
    end
  end

  // configuration registers; writes accepted only once started
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_ovr_r <= 1'b0; // R16
      slew_reg_r <= 1'b0;
      mid_ovr_r  <= 1'b0;
      mid_reg_r  <= 1'b0;
    end else if (ce && reg_wr && bus_open) begin // R8
      if (reg_addr == mps_pkg::ADDR_SLEW) begin
        slew_ovr_r <= 1'b1; // R5
        slew_reg_r <= reg_wdata[mps_pkg::SLEW_BIT];
      end
      if (reg_addr == mps_pkg::ADDR_MIDDRV) begin
        mid_ovr_r <= 1'b1; // R10
        mid_reg_r <= reg_wdata[mps_pkg::MIDDRV_BIT];
      end
    end
  end

  // read data for one cycle after the strobe; zero while closed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= mps_pkg::REG_RST;
    end else if (ce) begin
      reg_rdata <= mps_pkg::REG_RST;
      if (reg_rd && bus_open) begin // R8
        unique case (reg_addr)
          mps_pkg::ADDR_STATUS:
            reg_rdata <= {2'b00, pg_release_r, fault_r, sensed_r,
                          state_r};
          mps_pkg::ADDR_SLEW:
            reg_rdata <= 8'(slew_fast) << mps_pkg::SLEW_BIT;
          mps_pkg::ADDR_MIDDRV:
            reg_rdata <= 8'(mid_ovr_r ? mid_reg_r : cfg_r.mid_en)
                         << mps_pkg::MIDDRV_BIT;
          default: reg_rdata <= mps_pkg::REG_RST;
        endcase
      end
    end
  end

  // phase outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_drive <= '0;
      pwm_oe    <= '0;
      pwm_mid   <= 1'b0;
    end else if (ce) begin
      pwm_drive <= '0;
      pwm_oe    <= '0;
      pwm_mid   <= 1'b0;
      if ((switching || state_r == mps_pkg::ST_STOP) && !fault_r) begin
        pwm_drive <= pwm_demand; // R17
        pwm_oe    <= '1;
      end else if (state_r == mps_pkg::ST_LOWP) begin
        pwm_oe <= '1; // R18
      end else if (state_r == mps_pkg::ST_DELAY || fault_r) begin
        // first boot leaves the pins floating, a re-start holds mid level when mid drive is active
        pwm_mid <= mid_active && !first_boot_r; // R4 R15
      end
    end
  end

  // power good, voltage-id buffer and analog switch controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_release_r              <= 1'b0;
      reference_adjust_out_o    <= 1'b0;
      stage_reference_hold      <= 1'b0;
      stage_reference_discharge <= 1'b0;
      output_discharge          <= 1'b0;
    end else if (ce) begin
      pg_release_r <= (state_nxt == mps_pkg::ST_GOOD) && !fault_r &&
                      !en_off; // R6 R22
      reference_adjust_out_o <= sync_b_r.vid; // R20
      stage_reference_hold <= mode_b_r &&
        (state_r == mps_pkg::ST_DELAY || switching);
      stage_reference_discharge <= mode_b_r &&
        (state_r == mps_pkg::ST_OFF || stopping); // R19
      output_discharge <= (state_r == mps_pkg::ST_OFF ||
                           state_r == mps_pkg::ST_LOWP); // R19
    end
  end

  assign power_good_flag_o       = 1'b0;
  assign power_good_flag_oe      = !pg_release_r || fault_r; // R22
  assign reference_adjust_out_oe = pg_release_r; // R21

  // cycles spent from enable high until the sequencer reaches ST_GOOD
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bnd_cnt_r <= '0;
    end else if (ce) begin
      if (state_r == mps_pkg::ST_OFF) begin
        bnd_cnt_r <= '0;
      end else if (state_r != mps_pkg::ST_GOOD && !stopping &&
                   bnd_cnt_r != '1) begin // R7
        bnd_cnt_r <= bnd_cnt_r + 1'b1;
      end
    end
  end

  AST_PG_ONLY_GOOD: assert property (@(posedge clk) disable iff (!rst_n) // R6
    !power_good_flag_oe |-> state_r == mps_pkg::ST_GOOD && !fault_r)
    else $error("power good released outside regulation");

  AST_PG_EN_LOW: assert property (@(posedge clk) disable iff (!rst_n) // R22
    ce && en_off |=> power_good_flag_oe && !fault_r)
    else $error("power good or fault not cleared on enable low");

  AST_REF_HIZ: assert property (@(posedge clk) disable iff (!rst_n) // R21
    reference_adjust_out_oe |-> state_r == mps_pkg::ST_GOOD)
    else $error("reference adjust driven before power good");

  AST_REF_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n) // R20
    ce |=> reference_adjust_out_o == $past(sync_b_r.vid))
    else $error("reference adjust does not follow voltage id");

  AST_FIRST_HIZ: assert property (@(posedge clk) disable iff (!rst_n) // R4
    ce && state_r == mps_pkg::ST_DELAY && first_boot_r
    |=> pwm_oe == '0 && !pwm_mid)
    else $error("phase outputs driven during first-boot delay");

  AST_RESTART_MID: assert property (@(posedge clk) disable iff (!rst_n) // R15
    ce && state_r == mps_pkg::ST_DELAY && !first_boot_r && mid_active
    && !fault_r |=> pwm_mid && pwm_oe == '0)
    else $error("re-start delay not at tri-state level");

  AST_STOP_SEQ: assert property (@(posedge clk) disable iff (!rst_n) // R17
    ce && state_r == mps_pkg::ST_STOP && cnt_r == STOP_LAST
    |=> state_r == mps_pkg::ST_LOWP)
    else $error("stop delay length wrong");

  AST_LOW_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // R18
    ce && state_r == mps_pkg::ST_LOWP
    |=> pwm_oe == '1 && pwm_drive == '0 ##1 pwm_oe == '0)
    else $error("missing low pulse before tri-state");

  AST_BUS_CLOSED: assert property (@(posedge clk) disable iff (!rst_n) // R8
    ce && reg_rd && !bus_open |=> reg_rdata == 8'h00)
    else $error("register read answered before start-up end");

  AST_DISCHARGE: assert property (@(posedge clk) disable iff (!rst_n) // R19
    ce && state_r == mps_pkg::ST_LOWP |=> output_discharge)
    else $error("discharge not on at shutdown");

  AST_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // R7
    bnd_cnt_r <= CW'(BND_CYC))
    else $error("start-up exceeded its bound");

  AST_MID_RCV: assert property (@(posedge clk) disable iff (!rst_n) // R11
    pwm_mid |-> $past(mid_cnt_r) == MID_DONE)
    else $error("mid drive active before recovery");

endmodule
`default_nettype wire

// *** dv/mps_stage_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mps_stage_model #(
  parameter int unsigned LAG_CYC  = 16,
  parameter int unsigned VID_HALF = 16
) (
  // clock and supply reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // controller side
  input  wire logic       en_high,
  input  wire logic       mid_used,
  input  wire logic [7:0] pwm_oe,
  // host and stage answers
  output logic            vid,
  output logic            vout_ok,
  output logic            drv_en
);
  logic [15:0] lag_r;
  logic [7:0]  vid_cnt_r;

  // lag is shortened; only the order of the two enables matters here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lag_r  <= '0;
      drv_en <= 1'b0;
    end else if (!mid_used) begin
      drv_en <= 1'b1;
    end else if (!en_high) begin
      lag_r  <= '0;
      drv_en <= 1'b0;
    end else if (lag_r == 16'(LAG_CYC)) begin
      drv_en <= 1'b1;
    end else begin
      lag_r <= lag_r + 16'h1;
    end
  end

  // output counts as regulated only once the stage really switches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vout_ok <= 1'b0;
    end else begin
      vout_ok <= en_high & drv_en & (|pwm_oe);
    end
  end

  // host voltage-id source runs free, regardless of power good
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vid_cnt_r <= '0;
      vid       <= 1'b0;
    end else if (vid_cnt_r == 8'(VID_HALF - 1)) begin
      vid_cnt_r <= '0;
      vid       <= ~vid;
    end else begin
      vid_cnt_r <= vid_cnt_r + 8'h1;
    end
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int unsigned INI  = 20;
  localparam int unsigned DLY  = 10;
  localparam int unsigned MID  = 8;
  localparam int unsigned BND  = mps_pkg::BOUND_CYC;
  localparam int unsigned FAST = mps_pkg::RAMP_TARGET * mps_pkg::SLEW_FAST_CYC;
  localparam int unsigned SLOW = mps_pkg::RAMP_TARGET * mps_pkg::SLEW_SLOW_CYC;

  typedef struct packed {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } mps_tb_row_t;

  logic               clk, rst_n, ce, ism, reg_wr, reg_rd;
  mps_pkg::mps_pins_t pins, pins_b;
  logic [7:0]         pwm_demand, reg_addr, reg_wdata, reg_rdata;
  logic [7:0]         pwm_drive, pwm_oe, d, seen_oe;
  logic               pwm_mid, pg_o, pg_oe, ref_o, ref_oe, seen_mid, vid_prev;
  logic               sref_hold, sref_dis, out_dis, vid, vout_ok, drv_en;
  wire                pg_wire = pg_oe ? pg_o : 1'b1;
  int                 fail_count, checks_done, n, st;
  mps_tb_row_t        rows [6];

  always #4 clk = ~clk;
  always @(posedge clk) pwm_demand <= rst_n ? ~pwm_demand : 8'ha5;
  always_comb begin
    pins         = pins_b;
    pins.vid     = vid;
    pins.vout_ok = vout_ok;
  end

  mps_sequencer #(.PHASES(8), .INIT_CYC(INI), .DLY_CYC(DLY), .MID_CYC(MID),
    .BND_CYC(BND)) u_mps_sequencer (
    .clk(clk), .rst_n(rst_n), .ce(ce), .pins(pins),
    .integrated_stage_mode(ism), .pwm_demand(pwm_demand),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_drive(pwm_drive),
    .pwm_oe(pwm_oe), .pwm_mid(pwm_mid), .power_good_flag_o(pg_o),
    .power_good_flag_oe(pg_oe), .reference_adjust_out_o(ref_o),
    .reference_adjust_out_oe(ref_oe), .stage_reference_hold(sref_hold),
    .stage_reference_discharge(sref_dis), .output_discharge(out_dis));

  mps_stage_model u_mps_stage_model (
    .clk(clk), .rst_n(rst_n), .en_high(pins_b.en_hi), .mid_used(1'b1),
    .pwm_oe(pwm_oe), .vid(vid), .vout_ok(vout_ok), .drv_en(drv_en));

  task automatic chk(input string nm, input logic [15:0] s, logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // n counts cycles since enable went high
  task automatic wait_pg();
    while (pg_wire !== 1'b1 && n < (FAST + SLOW) / 2) begin
      tick();
      n++;
    end
    if (pg_wire !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic shutdown(input bit walk);
    int pg_k, off_k;
    bit pulse;
    pg_k  = 0;
    off_k = 0;
    pulse = 0;
    @(posedge clk);
    pins_b.en_hi    <= 1'b0;
    pins_b.en_sense <= 1'b0;
    pins_b.en_lo    <= 1'b1;
    for (int k = 1; k <= 60; k++) begin
      tick();
      if (pg_k == 0 && pg_wire === 1'b0) pg_k = k;
      if (pwm_oe === 8'hff && pwm_drive === 8'h00) pulse = 1;
      if (pulse && off_k == 0 && pwm_oe === 8'h00) off_k = k;
    end
    chk("pg_low_k", 16'(pg_k >= 1 && pg_k <= 4), 16'h1);
    chk("ref_oe_off", ref_oe, 1'b0);
    chk("out_dis", out_dis, 1'b1);
    chk("sref_dis", sref_dis, ism);
    if (walk) begin
      chk("low_pulse", pulse, 1'b1);
      chk("stop_k", 16'(off_k >= mps_pkg::STOP_DLY_CYC &&
        off_k <= mps_pkg::STOP_DLY_CYC + 8), 16'h1);
    end
  endtask

  initial begin
    clk         = 0;
    rst_n       = 0;
    ce          = 1;
    ism         = 1;
    reg_wr      = 0;
    reg_rd      = 0;
    reg_addr    = '0;
    reg_wdata   = '0;
    pins_b      = '0;
    pins_b.en_lo   = 1;
    pins_b.cfg_one = 1;
    fail_count  = 0;
    checks_done = 0;
    rows[0] = '{1'b1, 8'h43, 8'h08, 8'h00};
    rows[1] = '{1'b0, 8'h43, 8'h00, 8'h08};
    rows[2] = '{1'b0, 8'h40, 8'h00, 8'h02};
    rows[3] = '{1'b0, 8'h7f, 8'h00, 8'h00};
    rows[4] = '{1'b0, 8'h41, 8'h00, 8'h00};
    rows[5] = '{1'b0, 8'hff, 8'h00, 8'h00};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("pg_reset", pg_wire, 1'b0);
    chk("ref_oe_reset", ref_oe, 1'b0);
    chk("pwm_oe_reset", pwm_oe, 8'h00);
    wr(8'h43, 8'h08);
    rd(8'h00, d);
    chk("rd_closed", d, 8'h00);
    @(posedge clk);
    pins_b.en_lo    <= 1'b0;
    pins_b.en_sense <= 1'b1;
    repeat (INI + 8) tick();
    chk("ref_oe_init", ref_oe, 1'b0);
    @(posedge clk);
    pins_b.en_hi <= 1'b1;
    seen_oe  = '0;
    seen_mid = 0;
    for (n = 0; n < DLY + 3; n++) begin
      tick();
      seen_oe  |= pwm_oe;
      seen_mid |= pwm_mid;
    end
    chk("oe_delay", seen_oe, 8'h00);
    chk("mid_first", seen_mid, 1'b0);
    tick();
    n++;
    chk("oe_ramp", pwm_oe, 8'hff);
    wait_pg();
    chk("boot_bound", 16'(n <= BND), 16'h1);
    chk("slew_fast", 16'(n >= FAST && n < SLOW), 16'h1);
    chk("ref_oe_on", ref_oe, 1'b1);
    chk("sref_hold", sref_hold, 1'b1);
    st = 0;
    vid_prev = vid;
    repeat (64) begin
      tick();
      st = (vid === vid_prev) ? st + 1 : 0;
      vid_prev = vid;
      if (st >= 4) chk("ref_follow", ref_o, vid);
    end
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, d);
        chk("rd_row", d, rows[i].e);
      end
    end
    // clock enable low must freeze the phase outputs and power good
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) tick();
    d = pwm_drive;
    repeat (3) tick();
    chk("ce_hold", pwm_drive, d);
    chk("ce_pg", pg_wire, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    pins_b.uv <= 1'b1;
    @(posedge clk);
    pins_b.uv <= 1'b0;
    repeat (8) tick();
    chk("pg_fault", pg_wire, 1'b0);
    shutdown(0);
    rd(8'h00, d);
    chk("rd_after_off", d, 8'h00);
    // strap moved after first boot must not change the ramp
    @(posedge clk);
    pins_b.cfg_one  <= 1'b0;
    pins_b.en_lo    <= 1'b0;
    pins_b.en_sense <= 1'b1;
    pins_b.en_hi    <= 1'b1;
    ism             <= 1'b0;
    seen_mid = 0;
    for (n = 0; n < DLY + 4; n++) begin
      tick();
      if (n == 3) chk("mid_recover", pwm_mid, 1'b0);
      seen_mid |= pwm_mid;
    end
    chk("mid_restart", seen_mid, 1'b1);
    wait_pg();
    chk("restart_slew", 16'(n >= FAST && n < SLOW), 16'h1);
    rd(8'h43, d);
    chk("rd_kept", d, 8'h08);
    shutdown(1);
    test_done();
  end
endmodule
`default_nettype wire
